// ### common/psd_defines.vh
// constants for the power-up strap decoder
`ifndef PSD_DEFINES_VH
`define PSD_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define PSD_OFF_STATUS 4'h0
`define PSD_OFF_CONTROL 4'h4
`define PSD_OFF_LIVE 4'h8

// ****************************************
// status register fields
// ****************************************
`define PSD_ST_SOCKET 0
`define PSD_ST_XOR 1
`define PSD_ST_HIZ 2
`define PSD_ST_FREQ_LO 3
`define PSD_ST_FREQ_HI 4
`define PSD_ST_DEPTH_LO 5
`define PSD_ST_DEPTH_HI 7
`define PSD_ST_COLD 8

// ****************************************
// control register fields and reset value
// ****************************************
`define PSD_CT_FORCE_DEPTH1 0
`define PSD_CTRL_RESET 1'h0

// ****************************************
// pin vector positions
// ****************************************
`define PSD_PIN_SOCKET 0
`define PSD_PIN_XOR 1
`define PSD_PIN_HIZ 2
`define PSD_PIN_FREQ_LO 3
`define PSD_PIN_DEPTH 4
`define PSD_PIN_FREQ_HI 5
`define PSD_PIN_CPU_RST 6
`define PSD_PIN_COLD_RST 7
`define PSD_PIN_COUNT 8
`define PSD_PIN_RESET 8'h00

// ****************************************
// decoded values
// ****************************************
`define PSD_FREQ_66 2'h0
`define PSD_FREQ_100 2'h1
`define PSD_FREQ_133 2'h2
`define PSD_DEPTH_4 3'h4
`define PSD_DEPTH_1 3'h1

// ****************************************
// bus answers
// ****************************************
`define PSD_RESP_OKAY 2'h0
`define PSD_RESP_SLVERR 2'h2
`define PSD_ZERO32 32'h0000_0000

`endif

// ### hw/psd_pin_sync.v
// three-flop synchroniser with agreement filter for strap and reset pins
`timescale 1ns/100ps
module psd_pin_sync #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] pin_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;

  // ****************************************
  // per-bit chain, a change counts once stages two and three agree
  // ****************************************
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!rst_n) begin
          stage1[i] <= RESET_VALUE[i];
          stage2[i] <= RESET_VALUE[i];
          stage3[i] <= RESET_VALUE[i];
          pin_out[i] <= RESET_VALUE[i];
        end else begin
          stage1[i] <= pin_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            pin_out[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule // psd_pin_sync

// ### hw/psd_strap_decoder.v
// power-up strap decoder with an axi4-lite status port
// Behaviour
// RL1: socket strap 0 or float is pin socket
// RL2: capture all straps during cold reset; the queue-depth strap is latched at the processor reset rise instead
// RL3: xor strap 1 at reset enters xor test
// RL4: board holds xor strap high throughout test
// RL5: all-z strap 1 at reset tristates outputs
// RL6: high strap 133, else low strap 66/100
// RL7: queue-depth strap at processor reset rise: 4/1
// RL8: latched straps held until next cold reset; the depth strap is latched again at every processor reset rise
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "psd_defines.vh"
module psd_strap_decoder (
  input wire clk,
  input wire rst_n,
  input wire cold_reset_n,
  input wire processor_reset_n,
  input wire socket_type_strap,
  input wire xor_test_strap,
  input wire all_outputs_hiz_strap,
  input wire host_freq_low_strap,
  input wire host_freq_high_strap,
  input wire queue_depth_strap,
  output reg socket_is_slot,
  output reg xor_test_mode,
  output reg all_outputs_hiz,
  output reg [1:0] host_freq_sel,
  output reg [2:0] in_order_queue_depth,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  wire [`PSD_PIN_COUNT-1:0] raw_pins;
  wire [`PSD_PIN_COUNT-1:0] pins;
  wire cold_active;
  wire cpu_rst_rise;
  reg cpu_rst_prev;
  reg depth_prev;
  reg lat_socket;
  reg lat_xor;
  reg lat_hiz;
  reg lat_freq_lo;
  reg lat_freq_hi;
  reg lat_depth;
  reg force_depth1;
  reg [1:0] next_freq;
  reg [2:0] next_depth;
  reg [3:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg w_strb0;
  reg w_held;
  reg [31:0] read_word;
  reg read_ok;

  // ****************************************
  // pin synchronisers
  // ****************************************
  assign raw_pins = {cold_reset_n, processor_reset_n, host_freq_high_strap,
                     queue_depth_strap, host_freq_low_strap, all_outputs_hiz_strap,
                     xor_test_strap, socket_type_strap};

  psd_pin_sync #(
    .WIDTH(`PSD_PIN_COUNT),
    .RESET_VALUE(`PSD_PIN_RESET)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(raw_pins),
    .pin_out(pins)
  );

  assign cold_active = ~pins[`PSD_PIN_COLD_RST];
  assign cpu_rst_rise = pins[`PSD_PIN_CPU_RST] & ~cpu_rst_prev;

  // ****************************************
  // strap capture
  // ****************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      lat_socket <= 1'b0;
      lat_xor <= 1'b0;
      lat_hiz <= 1'b0;
      lat_freq_lo <= 1'b0;
      lat_freq_hi <= 1'b0;
      lat_depth <= 1'b0;
      cpu_rst_prev <= 1'b0;
      depth_prev <= 1'b0;
    end else begin
      cpu_rst_prev <= pins[`PSD_PIN_CPU_RST];
      depth_prev <= pins[`PSD_PIN_DEPTH];
      // track the pins only while cold reset is asserted, then freeze [RL2] [RL8]
      if (cold_active) begin
        lat_socket <= pins[`PSD_PIN_SOCKET]; // [RL1]
        lat_xor <= pins[`PSD_PIN_XOR]; // [RL3]
        lat_hiz <= pins[`PSD_PIN_HIZ]; // [RL5]
        lat_freq_lo <= pins[`PSD_PIN_FREQ_LO]; // [RL6]
        lat_freq_hi <= pins[`PSD_PIN_FREQ_HI]; // [RL6]
      end
      // depth strap as it stood just before the processor reset rising edge [RL7]
      // the shared pin may carry traffic from that edge on
      if (cpu_rst_rise) begin
        lat_depth <= depth_prev;
      end
    end
  end

  // ****************************************
  // decode
  // ****************************************
  always @* begin
    if (lat_freq_hi) begin
      next_freq = `PSD_FREQ_133; // [RL6]
    end else if (lat_freq_lo) begin
      next_freq = `PSD_FREQ_100; // [RL6]
    end else begin
      next_freq = `PSD_FREQ_66; // [RL6]
    end
    if (lat_depth | force_depth1) begin
      next_depth = `PSD_DEPTH_1; // [RL7]
    end else begin
      next_depth = `PSD_DEPTH_4; // [RL7]
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      socket_is_slot <= 1'b0;
      xor_test_mode <= 1'b0;
      all_outputs_hiz <= 1'b0;
      host_freq_sel <= `PSD_FREQ_66;
      in_order_queue_depth <= `PSD_DEPTH_4;
    end else begin
      socket_is_slot <= lat_socket; // [RL1]
      // test ends once the board lets the strap fall [RL3] [RL4]
      xor_test_mode <= lat_xor & pins[`PSD_PIN_XOR];
      all_outputs_hiz <= lat_hiz; // [RL5]
      host_freq_sel <= next_freq;
      in_order_queue_depth <= next_depth;
    end
  end

  // ****************************************
  // axi4-lite write path
  // ****************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSD_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= `PSD_ZERO32;
      w_strb0 <= 1'b0;
      force_depth1 <= `PSD_CTRL_RESET;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
      end
      if (aw_held & w_held & ~s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `PSD_OFF_CONTROL) begin
          s_axi_bresp <= `PSD_RESP_OKAY;
          if (w_strb0) begin
            force_depth1 <= w_data[`PSD_CT_FORCE_DEPTH1];
          end
        end else if (aw_addr == `PSD_OFF_STATUS || aw_addr == `PSD_OFF_LIVE) begin
          s_axi_bresp <= `PSD_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PSD_RESP_SLVERR;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  always @* begin
    read_word = `PSD_ZERO32;
    read_ok = 1'b1;
    case (s_axi_araddr)
      `PSD_OFF_STATUS: begin
        read_word[`PSD_ST_SOCKET] = socket_is_slot;
        read_word[`PSD_ST_XOR] = xor_test_mode;
        read_word[`PSD_ST_HIZ] = all_outputs_hiz;
        read_word[`PSD_ST_FREQ_HI:`PSD_ST_FREQ_LO] = host_freq_sel;
        read_word[`PSD_ST_DEPTH_HI:`PSD_ST_DEPTH_LO] = in_order_queue_depth;
        read_word[`PSD_ST_COLD] = cold_active;
      end
      `PSD_OFF_CONTROL: begin
        read_word[`PSD_CT_FORCE_DEPTH1] = force_depth1;
      end
      `PSD_OFF_LIVE: begin
        read_word[`PSD_PIN_COUNT-1:0] = pins;
      end
      default: begin
        read_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `PSD_ZERO32;
      s_axi_rresp <= `PSD_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_ok ? `PSD_RESP_OKAY : `PSD_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // psd_strap_decoder

// ### tb/psd_strap_monitor.sv
// port checker for the strap decoder
`timescale 1ns/100ps
module psd_strap_monitor (
  input logic clk,
  input logic rst_n,
  input logic cold_reset_n,
  input logic processor_reset_n,
  input logic queue_depth_strap,
  input logic socket_type_strap,
  input logic xor_test_strap,
  input logic all_outputs_hiz_strap,
  input logic host_freq_low_strap,
  input logic host_freq_high_strap,
  input logic socket_is_slot,
  input logic xor_test_mode,
  input logic all_outputs_hiz,
  input logic [1:0] host_freq_sel,
  input logic [2:0] in_order_queue_depth,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  logic [4:0] sv;
  logic [3:0] lo, hi, st;
  logic [3:0] cpu_hi;
  logic dq;
  wire [4:0] sp = {host_freq_high_strap, host_freq_low_strap, all_outputs_hiz_strap,
    xor_test_strap, socket_type_strap};
  // straps and cold reset settled long enough to pass the synchronisers
  wire ok = lo > 4'h7 && st > 4'h7;
  always_ff @(posedge clk) begin
    sv <= sp;
    lo <= (!rst_n || cold_reset_n) ? 4'h0 : lo + {3'h0, lo != 4'hf};
    hi <= (!rst_n || !cold_reset_n) ? 4'h0 : hi + {3'h0, hi != 4'hf};
    st <= (!rst_n || sp != sv) ? 4'h0 : st + {3'h0, st != 4'hf};
    cpu_hi <= (!rst_n || !processor_reset_n) ? 4'h0 : cpu_hi + {3'h0, cpu_hi != 4'hf};
    if (!processor_reset_n) dq <= queue_depth_strap;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_socket_track: assert property (ok |-> socket_is_slot == socket_type_strap)
    else $error("socket type wrong");
  chk_xor_track: assert property (ok |-> xor_test_mode == xor_test_strap)
    else $error("xor mode wrong");
  chk_hiz_track: assert property (ok |-> all_outputs_hiz == all_outputs_hiz_strap)
    else $error("hiz wrong");
  chk_freq_decode: assert property (ok |->
    host_freq_sel == (host_freq_high_strap ? 2'h2 : {1'b0, host_freq_low_strap}))
    else $error("freq wrong");
  chk_latch_hold: assert property (hi > 4'h8 |->
    $stable({socket_is_slot, all_outputs_hiz, host_freq_sel}))
    else $error("latched straps moved");
  chk_depth_legal: assert property (in_order_queue_depth inside {3'h1, 3'h4})
    else $error("depth illegal");
  chk_depth_strap: assert property (cpu_hi == 4'h8 && dq |-> in_order_queue_depth == 3'h1)
    else $error("depth strap not applied");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
endmodule // psd_strap_monitor

bind psd_strap_decoder psd_strap_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .cold_reset_n(cold_reset_n), .processor_reset_n(processor_reset_n),
  .queue_depth_strap(queue_depth_strap), .socket_type_strap(socket_type_strap),
  .xor_test_strap(xor_test_strap), .all_outputs_hiz_strap(all_outputs_hiz_strap),
  .host_freq_low_strap(host_freq_low_strap), .host_freq_high_strap(host_freq_high_strap),
  .socket_is_slot(socket_is_slot), .xor_test_mode(xor_test_mode),
  .all_outputs_hiz(all_outputs_hiz), .host_freq_sel(host_freq_sel),
  .in_order_queue_depth(in_order_queue_depth), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### tb/psd_strap_board.sv
// board strap resistors sharing the display memory data pins
`timescale 1ns/100ps
module psd_strap_board (
  input logic clk,
  input logic cold_reset_n,
  input logic processor_reset_n,
  input logic [5:0] strap_set,
  input logic hold_xor,
  output logic [5:0] pins
);
  logic [5:0] act = 6'h00;
  // memory traffic on the data pins except the xor strap pin once both resets are gone
  always @(posedge clk) act <= act + 6'h25;
  wire on = !cold_reset_n || !processor_reset_n;
  assign pins = on ? strap_set : {act[5:2], hold_xor & strap_set[1], act[0]};
endmodule // psd_strap_board

// ### tb/tb_top.sv
// self-checking bench for the strap decoder
`timescale 1ns/100ps
`include "psd_defines.vh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cold_n = 1'b0;
  logic cpu_n = 1'b0;
  logic hold = 1'b0;
  logic [5:0] sset = 6'h00;
  logic [5:0] pins;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int num_errors = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  psd_strap_board board (.clk(clk), .cold_reset_n(cold_n), .processor_reset_n(cpu_n),
    .strap_set(sset), .hold_xor(hold), .pins(pins));
  psd_strap_decoder DUT (.clk(clk), .rst_n(rst_n), .cold_reset_n(cold_n),
    .processor_reset_n(cpu_n), .socket_type_strap(pins[0]), .xor_test_strap(pins[1]),
    .all_outputs_hiz_strap(pins[2]), .host_freq_low_strap(pins[3]),
    .host_freq_high_strap(pins[4]), .queue_depth_strap(pins[5]), .socket_is_slot(),
    .xor_test_mode(), .all_outputs_hiz(), .host_freq_sel(), .in_order_queue_depth(),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic compare_read(input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED read expected %h seen %h", e, g);
    end
  endtask
  task automatic compare_bresp(input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED bresp expected %h seen %h", e, g);
    end
  endtask
  always @(posedge clk) begin
    if (rvalid && rready) compare_read(rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) compare_bresp(bq.pop_front(), bresp);
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // status word expected from straps, xor hold and the depth override
  function automatic logic [33:0] st_exp(input logic [5:0] s, input logic h, input logic f);
    return {2'h0, 23'h00_0000, 1'b0, (f || s[5]) ? 3'h1 : 3'h4,
      s[4] ? 2'h2 : {1'b0, s[3]}, s[2], s[1] & h, s[0]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(72599));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`PSD_OFF_CONTROL, {2'h0, 31'h0000_0000, `PSD_CTRL_RESET});
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      cold_n <= 1'b0;
      cpu_n <= 1'b0;
      sset <= 6'($urandom);
      hold <= 1'($urandom);
      repeat (12) @(posedge clk);
      rd(`PSD_OFF_LIVE, {28'h000_0000, sset[4], sset[5], sset[3:0]});
      cold_n <= 1'b1;
      repeat (10) @(posedge clk);
      cpu_n <= 1'b1;
      repeat (12) @(posedge clk);
      rd(`PSD_OFF_STATUS, st_exp(sset, hold, 1'b0));
    end
    wr(`PSD_OFF_CONTROL, 32'h0000_0001, `PSD_RESP_OKAY);
    rd(`PSD_OFF_CONTROL, {`PSD_RESP_OKAY, 32'h0000_0001});
    rd(`PSD_OFF_STATUS, st_exp(sset, hold, 1'b1));
    wr(`PSD_OFF_STATUS, 32'h0000_00ff, `PSD_RESP_OKAY);
    wr(4'hc, 32'h0000_0000, `PSD_RESP_SLVERR);
    rd(4'hc, {`PSD_RESP_SLVERR, 32'h0000_0000});
    wr(`PSD_OFF_CONTROL, 32'h0000_0000, `PSD_RESP_OKAY);
    rd(`PSD_OFF_STATUS, st_exp(sset, hold, 1'b0));
    // a write without byte lane 0 leaves the control bit alone
    wstrb <= 4'he;
    wr(`PSD_OFF_CONTROL, 32'h0000_0001, `PSD_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`PSD_OFF_CONTROL, {`PSD_RESP_OKAY, 32'h0000_0000});
    rd(`PSD_OFF_STATUS, st_exp(sset, hold, 1'b0));
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule // tb_top
